/* File: rtl/spm_port_regs.vh */
// Register indices, field positions, reset values and timing counts of the serial port
`ifndef SPM_PORT_REGS_VH
`define SPM_PORT_REGS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define SPM_IDX_CTL       8'hf8
`define SPM_IDX_CFG       8'h9a
`define SPM_IDX_DAT       8'h9b
`define SPM_IDX_CKR       8'h9d

// ==========================================================
// Control register fields
`define SPM_CTL_DONE      7
`define SPM_CTL_WRITE_COLLISION_FLAG      6
`define SPM_CTL_MODE_FAULT_FLAG      5
`define SPM_CTL_OVR       4
`define SPM_CTL_BUSY      3
`define SPM_CTL_SEL       2
`define SPM_CTL_MASTER_ENABLE_BIT     1
`define SPM_CTL_EN        0

// ==========================================================
// Configuration register fields
`define SPM_CFG_CPHA      7
`define SPM_CFG_CPOL      6
`define SPM_CFG_BC_HI     5
`define SPM_CFG_BC_LO     3
`define SPM_CFG_FRS_HI    2
`define SPM_CFG_FRS_LO    0

// ==========================================================
// Reset values
`define SPM_RST_CTL       8'h00
`define SPM_RST_CFG       8'h00
`define SPM_RST_CKR       8'h00
`define SPM_RST_DAT       8'h00

// ==========================================================
// Timing: divider values below the floor give the fastest rate,
// a half period of four system clocks (bit rate = clock / 8)
`define SPM_DIV_FLOOR     8'h03
`define SPM_MIN_HALF      9'h004

`endif

/* File: rtl/spm_port.v */
// Four-wire serial port, master or slave, with Avalon-MM register access
`timescale 1ns/10ps
`include "spm_port_regs.vh"

// Function
// RL1: Bit rate never exceeds one eighth of the system clock.
// RL2: Master drives the master-to-slave line, MSB first; slaves only read it.
// RL3: Selected slave drives slave-to-master line MSB first, else high impedance.
// RL4: Only the master makes the serial clock; data moves in step with it.
// RL5: External master holds select low for the whole transfer.
// RL6: In master mode the select input disables the port.
// RL7: Transfers start only as master; master enable bit makes it master.
// RL8: Writing the data register in master mode starts a transfer.
// RL9: Master shifts data out at once while producing the serial clock.
// RL10: Transfer-complete flag sets at end of master transfer; raises request.
// RL11: Master frames are one to eight bits, chosen by config bits [2:0].
// RL12: Master shifts in while shifting out; received word becomes readable data.
// RL13: Data write during a transfer is dropped and sets write-collision flag.
// RL14: Data reads return a receive buffer separate from the shift register.
// RL15: Overrun flag sets if unread data remains when the last bit arrives.
// RL16: On overrun the old word is kept and the new word dropped.
// RL17: Enabled without master enable, port is a slave on the external clock.
// RL18: Slave transfer completes, setting the done flag, when select rises.
// RL19: Slave data write loads the shift register for the next transfer.
// RL20: Master enable plus low select sets the mode-fault flag.
// RL21: Phase picks first or second sampling edge; polarity picks idle level.
// RL22: Master clock is half system clock over divider plus one, floor clock/8.
// RL23: Busy flag shows a master transfer; selected flag is inverted select.
// RL24: Event flags stay set until software clears them.
module spm_port (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        sck_i,
  output wire        sck_o,
  output wire        sck_oe,
  input  wire        mosi_i,
  output wire        mosi_o,
  output wire        mosi_oe,
  input  wire        miso_i,
  output wire        miso_o,
  output wire        miso_oe,
  input  wire        slave_select_n,
  output wire        irq_req
);

  // ==========================================================
  // State
  reg        done_ff;
  reg        write_collision_flag_ff;
  reg        mode_fault_flag_ff;
  reg        ovr_ff;
  reg        master_enable_bit_ff;
  reg        en_ff;
  reg        cpha_ff;
  reg        cpol_ff;
  reg [2:0]  frs_ff;
  reg [7:0]  ckr_ff;
  reg [7:0]  rxbuf_ff;
  reg        unread_ff;
  reg [7:0]  sh_ff;
  reg        out_ff;
  reg        busy_ff;
  reg        sck_ff;
  reg [8:0]  div_ff;
  reg [3:0]  edge_ff;
  reg [2:0]  bitcnt_ff;
  reg        sck_prev_ff;
  reg        nss_prev_ff;
  reg        ack_ff;
  reg [31:0] rdata_ff;

  // Reset images as named constants, so single fields can be picked out
  localparam [7:0] RST_CTL = `SPM_RST_CTL;
  localparam [7:0] RST_CFG = `SPM_RST_CFG;

  // ==========================================================
  // Bus decode: one wait cycle, access takes effect when waitrequest drops
  wire       req      = avs_read | avs_write;
  wire       take     = req & ack_ff;
  wire [7:0] idx      = avs_address[9:2];
  wire       wr_lane  = avs_write & take & avs_byteenable[0];
  wire [7:0] wd       = avs_writedata[7:0];
  wire       ctl_wr   = wr_lane & (idx == `SPM_IDX_CTL);
  wire       cfg_wr   = wr_lane & (idx == `SPM_IDX_CFG);
  wire       ckr_wr   = wr_lane & (idx == `SPM_IDX_CKR);
  wire       dat_wr   = wr_lane & (idx == `SPM_IDX_DAT);
  wire       dat_rd   = avs_read & take & (idx == `SPM_IDX_DAT);

  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata    = rdata_ff;

  // ==========================================================
  // Mode decode
  wire master_mode = en_ff & master_enable_bit_ff;                 // RL7
  wire slave_mode  = en_ff & ~master_enable_bit_ff;                // RL17
  wire sel         = ~slave_select_n;
  wire mst_dis     = master_mode & sel;                // RL6 RL20
  wire s_busy      = slave_mode & sel;

  // ==========================================================
  // Master bit-rate divider: half period is divider+1, never under four clocks
  wire [8:0] half    = (ckr_ff < `SPM_DIV_FLOOR) ? `SPM_MIN_HALF :
                       ({1'b0, ckr_ff} + 9'h001);      // RL22 RL1
  wire       tick    = busy_ff & (div_ff == (half - 9'h001));
  wire       m_edge  = tick & ~mst_dis;

  // Slave edges come from the external clock, inputs are already synchronous
  wire       s_edge  = s_busy & (sck_i != sck_prev_ff); // RL4 RL17
  wire       s_lead  = (sck_i != cpol_ff);

  // Leading or trailing edge, then sample or shift as phase selects
  wire       ev      = m_edge | s_edge;
  wire       lead    = m_edge ? ~edge_ff[0] : s_lead;
  wire       sample  = ev & (lead ^ cpha_ff);          // RL21
  wire       shift   = ev & ~(lead ^ cpha_ff);
  wire       din     = master_mode ? miso_i : mosi_i;  // RL2 RL3

  // End of frame: master after 2N edges, slave on select release
  wire       m_last  = m_edge & (edge_ff == {frs_ff, 1'b1}); // RL11
  wire       s_end   = slave_mode & ~nss_prev_ff & slave_select_n; // RL18
  wire       fin     = m_last | s_end;

  // Received word: master keeps only the low N bits of the frame
  wire [7:0] sh_smp  = {sh_ff[6:0], din};
  wire [7:0] sh_last = sample ? sh_smp : sh_ff;
  wire [7:0] fmask   = 8'hff >> (~frs_ff);
  wire [7:0] rxword  = master_mode ? (sh_last & fmask) : sh_last; // RL12

  // Start and collision of a data write
  wire       m_start = dat_wr & master_mode & ~busy_ff & slave_select_n; // RL8
  wire       coll    = dat_wr & (busy_ff | s_busy);    // RL13
  wire       s_load  = dat_wr & ~master_mode & ~s_busy; // RL19

  // ==========================================================
  // Bus answer and read data, captured the cycle before the answer
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (avs_read & ~ack_ff) begin
        case (idx)
          `SPM_IDX_CTL: rdata_ff <= {24'h000000, done_ff, write_collision_flag_ff, mode_fault_flag_ff, ovr_ff,
                                     busy_ff, sel, master_enable_bit_ff, en_ff}; // RL23
          `SPM_IDX_CFG: rdata_ff <= {24'h000000, cpha_ff, cpol_ff, bitcnt_ff, frs_ff};
          `SPM_IDX_CKR: rdata_ff <= {24'h000000, ckr_ff};
          `SPM_IDX_DAT: rdata_ff <= {24'h000000, rxbuf_ff}; // RL14
          default:      rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Configuration; clock settings should only change while disabled
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      master_enable_bit_ff <= RST_CTL[`SPM_CTL_MASTER_ENABLE_BIT];
      en_ff    <= RST_CTL[`SPM_CTL_EN];
      cpha_ff  <= RST_CFG[`SPM_CFG_CPHA];
      cpol_ff  <= RST_CFG[`SPM_CFG_CPOL];
      frs_ff   <= RST_CFG[`SPM_CFG_FRS_HI:`SPM_CFG_FRS_LO];
      ckr_ff   <= `SPM_RST_CKR;
    end else begin
      if (ctl_wr) begin
        master_enable_bit_ff <= wd[`SPM_CTL_MASTER_ENABLE_BIT];                // RL7
        en_ff    <= wd[`SPM_CTL_EN];
      end
      if (cfg_wr) begin
        cpha_ff <= wd[`SPM_CFG_CPHA];                  // RL21
        cpol_ff <= wd[`SPM_CFG_CPOL];
        frs_ff  <= wd[`SPM_CFG_FRS_HI:`SPM_CFG_FRS_LO]; // RL11
      end
      if (ckr_wr) begin
        ckr_ff <= wd;
      end
    end
  end

  // ==========================================================
  // Sticky flags: writing 0 clears, a same-cycle hardware set wins
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
      mode_fault_flag_ff <= 1'b0;
      ovr_ff  <= 1'b0;
    end else begin
      done_ff <= fin | (done_ff & ~(ctl_wr & ~wd[`SPM_CTL_DONE])); // RL10 RL18 RL24
      write_collision_flag_ff <= coll | (write_collision_flag_ff & ~(ctl_wr & ~wd[`SPM_CTL_WRITE_COLLISION_FLAG])); // RL13 RL24
      mode_fault_flag_ff <= mst_dis | (mode_fault_flag_ff & ~(ctl_wr & ~wd[`SPM_CTL_MODE_FAULT_FLAG])); // RL20 RL24
      ovr_ff  <= (fin & unread_ff) | (ovr_ff & ~(ctl_wr & ~wd[`SPM_CTL_OVR])); // RL15 RL24
    end
  end

  // ==========================================================
  // Receive buffer: loaded only when the previous word was read
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxbuf_ff  <= `SPM_RST_DAT;
      unread_ff <= 1'b0;
    end else begin
      if (fin & ~unread_ff) begin
        rxbuf_ff  <= rxword;                           // RL12 RL14
        unread_ff <= 1'b1;
      end else if (dat_rd & ~fin) begin
        unread_ff <= 1'b0;                             // RL16
      end
    end
  end

  // ==========================================================
  // Shift register and output bit, shared by master and slave roles.
  // The output bit is a separate latch so the line changes only on loads, select fall and shift edges.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sh_ff     <= `SPM_RST_DAT;
      out_ff    <= 1'b0;
      bitcnt_ff <= 3'h0;
    end else begin
      if (m_start | s_load) begin
        sh_ff     <= wd;                               // RL9 RL19
        out_ff    <= wd[7];
        bitcnt_ff <= 3'h0;
      end else if (slave_mode & nss_prev_ff & sel) begin
        out_ff    <= sh_ff[7];                         // RL3
        bitcnt_ff <= 3'h0;
      end else if (sample) begin
        sh_ff     <= sh_smp;                           // RL2 RL12
        bitcnt_ff <= bitcnt_ff + 3'h1;
      end else if (shift) begin
        out_ff <= sh_ff[7];                            // RL2 RL3
      end
    end
  end

  // ==========================================================
  // Master sequencer: divider, clock toggle and edge count
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      sck_ff  <= 1'b0;
      div_ff  <= 9'h000;
      edge_ff <= 4'h0;
    end else begin
      if (m_start) begin
        busy_ff <= 1'b1;                               // RL23
        sck_ff  <= cpol_ff;
        div_ff  <= 9'h000;
        edge_ff <= 4'h0;
      end else if (busy_ff & (mst_dis | ~master_mode)) begin
        busy_ff <= 1'b0;                               // RL6
        sck_ff  <= cpol_ff;
      end else if (busy_ff) begin
        div_ff <= tick ? 9'h000 : (div_ff + 9'h001);
        if (m_edge) begin
          sck_ff  <= ~sck_ff;                          // RL4 RL9
          edge_ff <= edge_ff + 4'h1;
          if (m_last) begin
            busy_ff <= 1'b0;                           // RL23
          end
        end
      end else begin
        sck_ff <= cpol_ff;                             // RL21
      end
    end
  end

  // ==========================================================
  // Previous levels of the external clock and select, for edge detection
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_ff <= 1'b0;
      nss_prev_ff <= 1'b1;
    end else begin
      sck_prev_ff <= sck_i;
      nss_prev_ff <= slave_select_n;
    end
  end

  // ==========================================================
  // Pins: the slave line is released unless selected as a slave
  assign sck_o   = sck_ff;
  assign sck_oe  = master_mode;                        // RL4
  assign mosi_o  = out_ff;
  assign mosi_oe = master_mode;                        // RL2
  assign miso_o  = out_ff;
  assign miso_oe = s_busy;                             // RL3
  // Raw request; enabling it is the interrupt controller's job
  assign irq_req = done_ff | write_collision_flag_ff | mode_fault_flag_ff | ovr_ff; // RL10

endmodule

/* File: verification/spm_port_props.sv */
// Concurrent checks on the serial port pins and register bus handshake
`timescale 1ns/10ps
module spm_port_props (
  input wire       clock,
  input wire       rst_n,
  input wire       avs_read,
  input wire       avs_write,
  input wire       avs_waitrequest,
  input wire       sck_o,
  input wire       sck_oe,
  input wire       mosi_oe,
  input wire       miso_oe,
  input wire       slave_select_n,
  input wire       irq_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // First cycle of any request waits, the next one answers
  sequence bus_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Select held low for two cycles while master
  sequence sel_held;
    sck_oe && !slave_select_n ##1 !slave_select_n;
  endsequence
  bus_answer_a: assert property (bus_wait |=> !avs_waitrequest)
    else $error("bus answer late");
  clk_floor_a: assert property ($changed(sck_o) |=> $stable(sck_o) [*3])
    else $error("serial clock too fast");
  miso_hiz_a: assert property (slave_select_n |-> !miso_oe)
    else $error("miso driven while unselected");
  one_clocker_a: assert property (!(sck_oe && miso_oe))
    else $error("master and slave drivers both on");
  out_pair_a: assert property (sck_oe == mosi_oe)
    else $error("mosi enable differs from clock enable");
  flag_hold_a: assert property (irq_req && !avs_write |=> irq_req)
    else $error("flag dropped without a write");
  fault_flag_a: assert property (sel_held |-> ##[0:4] irq_req)
    else $error("mode fault not flagged");
  idle_clk_a: assert property (!sck_oe && !avs_write ##1 !sck_oe |-> $stable(sck_o))
    else $error("serial clock moved outside master mode");
endmodule

bind spm_port spm_port_props u_props (
  .clock(clock), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
  .miso_oe(miso_oe), .slave_select_n(slave_select_n), .irq_req(irq_req)
);

/* File: verification/spm_slave_model.sv */
// Behavioural far-side slave for master-mode transfers, mode 0
`timescale 1ns/10ps
module spm_slave_model (
  input  wire        sck,
  input  wire        mosi,
  input  wire [7:0]  word,
  input  wire        load,
  output logic       miso,
  output logic [7:0] got
);
  logic [7:0] sh;
  initial begin
    sh = 8'h00;
    miso = 1'b0;
    got = 8'h00;
  end
  // A new word shows its top bit at once
  always @(load) begin
    sh = word;
    miso = word[7];
  end
  // Sample on the leading edge of an idle-low clock
  always @(posedge sck) got = {got[6:0], mosi};
  // Spent bits refill inverted so a stale line never looks valid
  always @(negedge sck) begin
    sh = {sh[6:0], ~sh[7]};
    miso = sh[7];
  end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench: register access, master and slave transfers, fault flags
`timescale 1ns/10ps
`include "spm_port_regs.vh"
module testbench;
  localparam logic [9:0] A_CTL = {`SPM_IDX_CTL, 2'b00};
  localparam logic [9:0] A_CFG = {`SPM_IDX_CFG, 2'b00};
  localparam logic [9:0] A_DAT = {`SPM_IDX_DAT, 2'b00};
  localparam logic [9:0] A_CKR = {`SPM_IDX_CKR, 2'b00};
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic        sck_i = 1'b0;
  logic        mosi_i = 1'b0;
  logic        slave_select_n = 1'b1;
  logic        pload = 1'b0;
  logic [7:0]  pw = 8'h00;
  logic [7:0]  v, r, got;
  logic [7:0]  tk [4] = '{8'h00, 8'h02, 8'h03, 8'h09};
  logic [7:0]  tf [4] = '{8'h07, 8'h02, 8'h00, 8'h07};
  logic [7:0]  td [4] = '{8'ha5, 8'hc3, 8'h80, 8'h5e};
  logic [7:0]  tw [4] = '{8'h3c, 8'he1, 8'hff, 8'h96};
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, sck_o, sck_oe, mosi_o, mosi_oe, miso_i, miso_o, miso_oe, irq_req;
  int          miscompares = 0, n_checks = 0, cyc = 0, edges = 0, hi = 0, n, h;

  spm_port dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sck_i(sck_i),
    .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe), .slave_select_n(slave_select_n),
    .irq_req(irq_req));
  spm_slave_model pm (.sck(sck_o), .mosi(mosi_o), .word(pw), .load(pload), .miso(miso_i),
    .got(got));

  // Clock, serial clock edge and high-time counters, hang guard
  always #20 clock = ~clock;
  always @(posedge sck_o) edges++;
  always @(posedge clock) begin
    if (sck_o === 1'b1) hi++;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Loads the far side, then starts a master transfer
  task automatic xfer(input logic [7:0] k, input logic [7:0] f, input logic [7:0] d,
                      input logic [7:0] w);
    wr(A_CKR, k);
    wr(A_CFG, f);
    pw = w;
    pload = ~pload;
    edges = 0;
    hi = 0;
    wr(A_DAT, d);
  endtask
  task automatic wait_done();
    do rd(A_CTL, v); while (v[7] !== 1'b1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rd(A_CTL, v); chk("ctl", v, `SPM_RST_CTL);
    rd(A_CFG, v); chk("cfg", v, `SPM_RST_CFG);
    rd(A_CKR, v); chk("ckr", v, `SPM_RST_CKR);
    rd(A_DAT, v); chk("dat", v, `SPM_RST_DAT);
    wr(10'h000, 8'hff);
    rd(10'h000, v); chk("unmapped", v, 8'h00);
    $display("test reset done");
    // Dividers below, at and above the floor, short and full frames, collision mid-frame
    for (int i = 0; i < 4; i++) begin
      n = tf[i] + 1;
      h = (tk[i] < 8'h03) ? 4 : tk[i] + 1;
      wr(A_CTL, 8'h03);
      xfer(tk[i], tf[i], td[i], tw[i]);
      rd(A_CTL, v); chk("busy", v[3], 1'b1);
      wr(A_DAT, 8'hff);
      wait_done();
      chk("ctl end", v, 8'hc3);
      chk("irq", {7'h00, irq_req}, 8'h01);
      chk("edges", edges[7:0], n[7:0]);
      chk("high time", hi[7:0], 8'(n * h));
      chk("mosi bits", got & (8'hff >> (8 - n)), td[i] >> (8 - n));
      rd(A_DAT, v); chk("rx", v, tw[i] >> (8 - n));
      wr(A_CTL, 8'h03);
      // The clear lands at the edge the task returns on; look once it has settled
      @(negedge clock);
      chk("irq clear", {7'h00, irq_req}, 8'h00);
    end
    $display("test master done");
    xfer(8'h00, 8'h07, 8'h11, 8'h22);
    wait_done();
    wr(A_CTL, 8'h03);
    xfer(8'h00, 8'h07, 8'h33, 8'h44);
    wait_done();
    chk("overrun", v, 8'h93);
    rd(A_DAT, v); chk("kept word", v, 8'h22);
    wr(A_CTL, 8'h03);
    $display("test overrun done");
    edges = 0;
    @(posedge clock);
    slave_select_n <= 1'b0;
    repeat (6) @(posedge clock);
    wr(A_DAT, 8'h55);
    repeat (20) @(posedge clock);
    rd(A_CTL, v); chk("fault", v & 8'h26, 8'h26);
    chk("no clock", edges[7:0], 8'h00);
    slave_select_n <= 1'b1;
    wr(A_CTL, 8'h01);
    $display("test fault done");
    // Slave frame with a slow external clock, bench acting as master
    wr(A_DAT, 8'ha5);
    @(posedge clock);
    slave_select_n <= 1'b0;
    repeat (8) @(posedge clock);
    for (int i = 7; i >= 0; i--) begin
      mosi_i <= tw[0][i];
      repeat (8) @(posedge clock);
      sck_i <= 1'b1;
      r = {r[6:0], miso_o};
      repeat (8) @(posedge clock);
      sck_i <= 1'b0;
    end
    chk("miso oe", {7'h00, miso_oe}, 8'h01);
    repeat (8) @(posedge clock);
    slave_select_n <= 1'b1;
    mosi_i <= ~mosi_i;
    chk("miso bits", r, 8'ha5);
    repeat (4) @(posedge clock);
    rd(A_CTL, v); chk("slave done", v, 8'h81);
    rd(A_DAT, v); chk("slave rx", v, tw[0]);
    chk("miso off", {7'h00, miso_oe}, 8'h00);
    $display("test slave done");
    report_and_stop();
  end
endmodule
